// File: include/pcc_defines.vh
// constants of the panel command configuration block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

// command codes
`define PCC_CMD_SYSTEM_SET 8'h40
`define PCC_CMD_PLL_SET 8'h62
`define PCC_CMD_PANEL_SET1 8'h63

// parameter counts per command
`define PCC_SYS_PARAMS 4'h8
`define PCC_PLL_PARAMS 4'h3
`define PCC_PANEL_PARAMS 4'h1

// register offsets
`define PCC_OFS_SYSTEM_SETUP_FLAGS 8'h00
`define PCC_OFS_CHAR_WIDTH_CFG 8'h01
`define PCC_OFS_CHAR_HEIGHT_CFG 8'h02
`define PCC_OFS_LINE_DISPLAY_ADDRESSES 8'h03
`define PCC_OFS_LINE_TOTAL_ADDRESSES 8'h04
`define PCC_OFS_FRAME_DISPLAY_LINES 8'h05
`define PCC_OFS_VIRTUAL_WIDTH_LOW 8'h06
`define PCC_OFS_VIRTUAL_WIDTH_HIGH 8'h07
`define PCC_OFS_PLL_DIVIDERS 8'h31
`define PCC_OFS_PLL_MULTIPLIER 8'h32
`define PCC_OFS_PLL_VCO_CFG 8'h33
`define PCC_OFS_PANEL_IF_CONTROL 8'h34

// system setup flag bit positions, drive mode bit sits in the char width register
`define PCC_BIT_CHAR_ROM_SELECT 0
`define PCC_BIT_CHAR_LINE_COUNT 2
`define PCC_BIT_SCREEN_MODE 3
`define PCC_BIT_TOP_LINE_COMP 5
`define PCC_BIT_DRIVE_MODE 7

// panel control bit positions
`define PCC_BIT_PANEL_ENABLE 0
`define PCC_BIT_PANEL_COLOR 1
`define PCC_BIT_PANEL_SCALER 2
`define PCC_BIT_SHIFT_POL 4
`define PCC_BIT_DRDY_POL 5
`define PCC_BIT_LINE_POL 6
`define PCC_BIT_FRAME_POL 7

// reset values
`define PCC_RST_REG 8'h00
`define PCC_RST_CMD 8'h00

`endif

// File: rtl/pcc_panel_command_config.v
// command interpreter loading system, synthesizer and panel configuration
`timescale 1ns/100ps
`include "pcc_defines.vh"

module pcc_panel_command_config #(
  parameter DATA_W = 8
) (
  // clock and reset
  input wire SYS_CLK,
  input wire SRST,
  // host bus pins
  input wire [DATA_W-1:0] HOST_DATA,
  input wire HOST_CMD,
  input wire HOST_WR_N,
  // raw configuration registers
  output reg [7:0] SYSTEM_SETUP_FLAGS,
  output reg [7:0] CHAR_WIDTH_CFG,
  output reg [7:0] CHAR_HEIGHT_CFG,
  output reg [7:0] LINE_DISPLAY_ADDRESSES,
  output reg [7:0] LINE_TOTAL_ADDRESSES,
  output reg [7:0] FRAME_DISPLAY_LINES,
  output reg [7:0] VIRTUAL_WIDTH_LOW,
  output reg [7:0] VIRTUAL_WIDTH_HIGH,
  output reg [7:0] PLL_DIVIDERS,
  output reg [7:0] PLL_MULTIPLIER,
  output reg [7:0] PLL_VCO_CFG,
  output reg [7:0] PANEL_IF_CONTROL,
  // decoded system setup
  output reg CHAR_ROM_INTERNAL,
  output reg CHAR_EIGHT_LINES,
  output reg SCREEN_MODE,
  output reg SCREEN_MODE_CONFLICT,
  output reg TOP_LINE_COMP_EN,
  output reg DRIVE_MODE,
  output reg [4:0] CHAR_WIDTH,
  output reg [4:0] CHAR_HEIGHT,
  output reg [8:0] LINE_DISPLAY_COUNT,
  output reg [8:0] LINE_TOTAL_COUNT,
  output reg [8:0] FRAME_LINE_COUNT,
  output reg [14:0] VIRTUAL_WIDTH,
  // decoded synthesizer setup
  output reg [4:0] SYNTH_INPUT_DIVIDER,
  output reg [4:0] SYNTH_OUTPUT_DIVIDER,
  output reg [4:0] SYNTH_FEEDBACK_MULT,
  output reg [3:0] LOOP_RESISTOR_SELECT,
  output reg [4:0] LOOP_CAPACITOR_SELECT,
  output reg [2:0] VCO_MULT,
  // decoded panel setup
  output reg PANEL_ENABLE,
  output reg PANEL_GRAY,
  output reg PANEL_SCALE_NEAREST,
  output reg SHIFT_FALLING_EDGE,
  output reg DATA_READY_ACTIVE_HIGH,
  output reg LINE_SYNC_ACTIVE_HIGH,
  output reg FRAME_SYNC_ACTIVE_HIGH,
  // sequencer status
  output reg [7:0] ACTIVE_CMD,
  output reg [3:0] PARAM_INDEX,
  output reg PARAM_OVERRUN
);

  // sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_SYSTEM = 2'b01;
  localparam ST_PLL = 2'b10;
  localparam ST_PANEL = 2'b11;

  // three-stage synchronisers for the host pins
  reg [DATA_W-1:0] data_s1_ff;
  reg [DATA_W-1:0] data_s2_ff;
  reg [DATA_W-1:0] data_s3_ff;
  reg cmd_s1_ff;
  reg cmd_s2_ff;
  reg cmd_s3_ff;
  reg wr_s1_ff;
  reg wr_s2_ff;
  reg wr_s3_ff;
  reg wr_level_ff;

  // sequencer
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [3:0] index_ff;
  reg [3:0] nxt_index;
  reg [7:0] active_cmd_ff;
  reg [7:0] nxt_active_cmd;
  reg overrun_ff;
  reg nxt_overrun;
  reg wr_param;
  reg [7:0] target_ofs;

  // stroke accepted when stages two and three agree on the asserted level
  wire wr_take = (wr_s2_ff == wr_s3_ff) && !wr_s3_ff && wr_level_ff;
  wire [7:0] host_byte = data_s3_ff[7:0];

  // pin synchronisers, no logic between the stages
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      // data stages cleared
      data_s1_ff <= {DATA_W{1'b0}};
      data_s2_ff <= {DATA_W{1'b0}};
      data_s3_ff <= {DATA_W{1'b0}};
      // command flag stages cleared
      cmd_s1_ff <= 1'b0;
      cmd_s2_ff <= 1'b0;
      cmd_s3_ff <= 1'b0;
      // strobe stages park at the idle high level
      wr_s1_ff <= 1'b1;
      wr_s2_ff <= 1'b1;
      wr_s3_ff <= 1'b1;
    end else begin
      // data byte, three stages
      data_s1_ff <= HOST_DATA;
      data_s2_ff <= data_s1_ff;
      data_s3_ff <= data_s2_ff;
      // command flag, three stages
      cmd_s1_ff <= HOST_CMD;
      cmd_s2_ff <= cmd_s1_ff;
      cmd_s3_ff <= cmd_s2_ff;
      // write strobe, three stages
      wr_s1_ff <= HOST_WR_N;
      wr_s2_ff <= wr_s1_ff;
      wr_s3_ff <= wr_s2_ff;
    end
  end

  // settled strobe level, one accepted stroke per low period
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      wr_level_ff <= 1'b1;
    end else if (wr_s2_ff == wr_s3_ff) begin
      wr_level_ff <= wr_s3_ff;
    end
  end

  // command decode and parameter counting
  always @* begin
    // hold everything unless a stroke lands
    nxt_state = state_ff;
    nxt_index = index_ff;
    nxt_active_cmd = active_cmd_ff;
    nxt_overrun = overrun_ff;
    wr_param = 1'b0;
    target_ofs = `PCC_RST_REG;
    if (wr_take && cmd_s3_ff) begin
      // a new code always ends the running sequence
      nxt_active_cmd = host_byte;
      nxt_index = 4'h0;
      nxt_overrun = 1'b0;
      case (host_byte)
        `PCC_CMD_SYSTEM_SET: nxt_state = ST_SYSTEM;
        `PCC_CMD_PLL_SET: nxt_state = ST_PLL;
        `PCC_CMD_PANEL_SET1: nxt_state = ST_PANEL;
        default: nxt_state = ST_IDLE;
      endcase
    end else if (wr_take) begin
      case (state_ff)
        ST_SYSTEM: begin
          // params one to eight land in offsets 00h..07h in order
          if (index_ff < `PCC_SYS_PARAMS) begin
            wr_param = 1'b1;
            target_ofs = `PCC_OFS_SYSTEM_SETUP_FLAGS + {4'h0, index_ff};
          end
        end
        ST_PLL: begin
          // params one to three land in 31h..33h in order
          if (index_ff < `PCC_PLL_PARAMS) begin
            wr_param = 1'b1;
            target_ofs = `PCC_OFS_PLL_DIVIDERS + {4'h0, index_ff};
          end
        end
        ST_PANEL: begin
          // the single param lands in 34h
          if (index_ff < `PCC_PANEL_PARAMS) begin
            wr_param = 1'b1;
            target_ofs = `PCC_OFS_PANEL_IF_CONTROL;
          end
        end
        default: begin
          // no open command, the byte is an orphan
          wr_param = 1'b0;
        end
      endcase
      // count accepted bytes, flag the rest
      if (wr_param) begin
        nxt_index = index_ff + 4'h1;
      end else begin
        nxt_overrun = 1'b1; // extra or orphan byte dropped
      end
    end
  end

  // sequencer registers
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      // idle with no command seen
      state_ff <= ST_IDLE;
      index_ff <= 4'h0;
      active_cmd_ff <= `PCC_RST_CMD;
      overrun_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      index_ff <= nxt_index;
      active_cmd_ff <= nxt_active_cmd;
      overrun_ff <= nxt_overrun;
    end
  end

  // configuration register file written by parameter bytes
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      // system setup bank cleared
      SYSTEM_SETUP_FLAGS <= `PCC_RST_REG;
      CHAR_WIDTH_CFG <= `PCC_RST_REG;
      CHAR_HEIGHT_CFG <= `PCC_RST_REG;
      LINE_DISPLAY_ADDRESSES <= `PCC_RST_REG;
      LINE_TOTAL_ADDRESSES <= `PCC_RST_REG;
      FRAME_DISPLAY_LINES <= `PCC_RST_REG;
      VIRTUAL_WIDTH_LOW <= `PCC_RST_REG;
      VIRTUAL_WIDTH_HIGH <= `PCC_RST_REG;
      // synthesizer bank cleared
      PLL_DIVIDERS <= `PCC_RST_REG;
      PLL_MULTIPLIER <= `PCC_RST_REG;
      PLL_VCO_CFG <= `PCC_RST_REG;
      // panel control cleared
      PANEL_IF_CONTROL <= `PCC_RST_REG;
    end else if (wr_param) begin
      case (target_ofs)
        // system setup bank, 00h..07h
        `PCC_OFS_SYSTEM_SETUP_FLAGS: SYSTEM_SETUP_FLAGS <= host_byte;
        `PCC_OFS_CHAR_WIDTH_CFG: CHAR_WIDTH_CFG <= host_byte;
        `PCC_OFS_CHAR_HEIGHT_CFG: CHAR_HEIGHT_CFG <= host_byte;
        `PCC_OFS_LINE_DISPLAY_ADDRESSES: LINE_DISPLAY_ADDRESSES <= host_byte;
        `PCC_OFS_LINE_TOTAL_ADDRESSES: LINE_TOTAL_ADDRESSES <= host_byte;
        `PCC_OFS_FRAME_DISPLAY_LINES: FRAME_DISPLAY_LINES <= host_byte;
        `PCC_OFS_VIRTUAL_WIDTH_LOW: VIRTUAL_WIDTH_LOW <= host_byte;
        `PCC_OFS_VIRTUAL_WIDTH_HIGH: VIRTUAL_WIDTH_HIGH <= host_byte;
        // synthesizer bank, 31h..33h
        `PCC_OFS_PLL_DIVIDERS: PLL_DIVIDERS <= host_byte;
        `PCC_OFS_PLL_MULTIPLIER: PLL_MULTIPLIER <= host_byte;
        `PCC_OFS_PLL_VCO_CFG: PLL_VCO_CFG <= host_byte;
        // panel control, 34h
        `PCC_OFS_PANEL_IF_CONTROL: PANEL_IF_CONTROL <= host_byte;
        // no other offset is ever aimed at
        default: PANEL_IF_CONTROL <= PANEL_IF_CONTROL;
      endcase
    end
  end

  // panel use seen straight from the control register
  wire panel_on = PANEL_IF_CONTROL[`PCC_BIT_PANEL_ENABLE];

  // decoded system setup fields, one cycle behind the raw registers
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      // mode flags as decoded from a zero register
      CHAR_ROM_INTERNAL <= 1'b1;
      CHAR_EIGHT_LINES <= 1'b1;
      SCREEN_MODE <= 1'b0;
      SCREEN_MODE_CONFLICT <= 1'b0;
      TOP_LINE_COMP_EN <= 1'b1;
      DRIVE_MODE <= 1'b0;
      // sizes and counts, a zero field means one, virtual width reads zero
      CHAR_WIDTH <= 5'h01;
      CHAR_HEIGHT <= 5'h01;
      LINE_DISPLAY_COUNT <= 9'h001;
      LINE_TOTAL_COUNT <= 9'h001;
      FRAME_LINE_COUNT <= 9'h001;
      VIRTUAL_WIDTH <= 15'h0000;
    end else begin
      // single-bit mode flags
      CHAR_ROM_INTERNAL <= ~SYSTEM_SETUP_FLAGS[`PCC_BIT_CHAR_ROM_SELECT];
      CHAR_EIGHT_LINES <= ~SYSTEM_SETUP_FLAGS[`PCC_BIT_CHAR_LINE_COUNT];
      // screen mode forced off while the panel runs
      SCREEN_MODE <= SYSTEM_SETUP_FLAGS[`PCC_BIT_SCREEN_MODE] & ~panel_on;
      SCREEN_MODE_CONFLICT <= SYSTEM_SETUP_FLAGS[`PCC_BIT_SCREEN_MODE] & panel_on;
      TOP_LINE_COMP_EN <= ~SYSTEM_SETUP_FLAGS[`PCC_BIT_TOP_LINE_COMP];
      DRIVE_MODE <= CHAR_WIDTH_CFG[`PCC_BIT_DRIVE_MODE] & ~panel_on;
      // stored value plus one, carry kept in the extra bit
      CHAR_WIDTH <= {1'b0, CHAR_WIDTH_CFG[3:0]} + 5'h01;
      CHAR_HEIGHT <= {1'b0, CHAR_HEIGHT_CFG[3:0]} + 5'h01;
      LINE_DISPLAY_COUNT <= {1'b0, LINE_DISPLAY_ADDRESSES} + 9'h001;
      LINE_TOTAL_COUNT <= {1'b0, LINE_TOTAL_ADDRESSES} + 9'h001;
      FRAME_LINE_COUNT <= {1'b0, FRAME_DISPLAY_LINES} + 9'h001;
      // width joins the low byte and bits 6..0 of the high byte with no offset
      VIRTUAL_WIDTH <= {VIRTUAL_WIDTH_HIGH[6:0], VIRTUAL_WIDTH_LOW};
    end
  end

  // decoded synthesizer setup, divider and multiplier fields count from one
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      // dividers and multipliers read as one
      SYNTH_INPUT_DIVIDER <= 5'h01;
      SYNTH_OUTPUT_DIVIDER <= 5'h01;
      SYNTH_FEEDBACK_MULT <= 5'h01;
      // loop filter selects cleared
      LOOP_RESISTOR_SELECT <= 4'h0;
      LOOP_CAPACITOR_SELECT <= 5'h00;
      VCO_MULT <= 3'h1;
    end else begin
      // divider and multiplier nibbles plus one
      SYNTH_INPUT_DIVIDER <= {1'b0, PLL_DIVIDERS[3:0]} + 5'h01;
      SYNTH_OUTPUT_DIVIDER <= {1'b0, PLL_DIVIDERS[7:4]} + 5'h01;
      SYNTH_FEEDBACK_MULT <= {1'b0, PLL_MULTIPLIER[3:0]} + 5'h01;
      // loop filter selects pass straight through, VCO field plus one
      LOOP_RESISTOR_SELECT <= PLL_MULTIPLIER[7:4];
      LOOP_CAPACITOR_SELECT <= PLL_VCO_CFG[4:0];
      VCO_MULT <= {1'b0, PLL_VCO_CFG[6:5]} + 3'h1;
    end
  end

  // decoded panel interface controls
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      // panel off, polarities of a zero register
      PANEL_ENABLE <= 1'b0;
      PANEL_GRAY <= 1'b1;
      PANEL_SCALE_NEAREST <= 1'b0;
      SHIFT_FALLING_EDGE <= 1'b1;
      DATA_READY_ACTIVE_HIGH <= 1'b0;
      LINE_SYNC_ACTIVE_HIGH <= 1'b0;
      FRAME_SYNC_ACTIVE_HIGH <= 1'b0;
    end else begin
      // enable and picture modes
      PANEL_ENABLE <= panel_on;
      PANEL_GRAY <= ~PANEL_IF_CONTROL[`PCC_BIT_PANEL_COLOR];
      PANEL_SCALE_NEAREST <= PANEL_IF_CONTROL[`PCC_BIT_PANEL_SCALER];
      // edge and sync polarities
      SHIFT_FALLING_EDGE <= ~PANEL_IF_CONTROL[`PCC_BIT_SHIFT_POL];
      DATA_READY_ACTIVE_HIGH <= PANEL_IF_CONTROL[`PCC_BIT_DRDY_POL];
      LINE_SYNC_ACTIVE_HIGH <= PANEL_IF_CONTROL[`PCC_BIT_LINE_POL];
      FRAME_SYNC_ACTIVE_HIGH <= PANEL_IF_CONTROL[`PCC_BIT_FRAME_POL];
    end
  end

  // sequencer status outputs
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      // nothing received yet
      ACTIVE_CMD <= `PCC_RST_CMD;
      PARAM_INDEX <= 4'h0;
      PARAM_OVERRUN <= 1'b0;
    end else begin
      ACTIVE_CMD <= active_cmd_ff;
      PARAM_INDEX <= index_ff;
      PARAM_OVERRUN <= overrun_ff;
    end
  end

endmodule // pcc_panel_command_config

// File: testbench/pcc_host_model.sv
// host processor model driving the 8-bit command bus
`timescale 1ns/100ps
module pcc_host_model #(
  parameter int XTAL_WAIT = 0
) (
  // clock
  input wire logic SYS_CLK,
  // host bus
  output logic [7:0] HOST_DATA,
  output logic HOST_CMD,
  output logic HOST_WR_N,
  // one-cycle flag after each finished byte
  output logic byte_done
);
  // idle bus at time zero
  initial begin
    HOST_DATA = 8'h00;
    HOST_CMD = 1'b0;
    HOST_WR_N = 1'b1;
    byte_done = 1'b0;
  end

  // one byte: setup, strobe low, release, recovery
  task automatic put(input logic c, input logic [7:0] d, input int slow);
    @(negedge SYS_CLK);
    HOST_CMD = c;
    HOST_DATA = d;
    @(negedge SYS_CLK);
    HOST_WR_N = 1'b0;
    repeat (4 + slow) @(negedge SYS_CLK);
    HOST_WR_N = 1'b1;
    @(negedge SYS_CLK);
    HOST_DATA = ~d; // released bus shows no stale byte
    HOST_CMD = ~c;
    if (c && d == 8'h40) repeat (XTAL_WAIT) @(negedge SYS_CLK);
    repeat (3 + slow) @(negedge SYS_CLK);
    byte_done = 1'b1;
    @(negedge SYS_CLK);
    byte_done = 1'b0;
  endtask
endmodule // pcc_host_model

// File: testbench/pcc_cfg_monitor.sv
// assertion checker bound to the command configuration block
`timescale 1ns/100ps
module pcc_cfg_monitor (
  // clock, reset, strobe
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic HOST_WR_N,
  // raw registers
  input wire logic [7:0] SYSTEM_SETUP_FLAGS,
  input wire logic [7:0] CHAR_WIDTH_CFG,
  input wire logic [7:0] CHAR_HEIGHT_CFG,
  input wire logic [7:0] LINE_DISPLAY_ADDRESSES,
  input wire logic [7:0] VIRTUAL_WIDTH_LOW,
  input wire logic [7:0] VIRTUAL_WIDTH_HIGH,
  input wire logic [7:0] PLL_DIVIDERS,
  input wire logic [7:0] PLL_MULTIPLIER,
  input wire logic [7:0] PLL_VCO_CFG,
  input wire logic [7:0] PANEL_IF_CONTROL,
  // decoded fields
  input wire logic CHAR_ROM_INTERNAL,
  input wire logic CHAR_EIGHT_LINES,
  input wire logic TOP_LINE_COMP_EN,
  input wire logic DRIVE_MODE,
  input wire logic [4:0] CHAR_WIDTH,
  input wire logic [4:0] CHAR_HEIGHT,
  input wire logic [8:0] LINE_DISPLAY_COUNT,
  input wire logic [14:0] VIRTUAL_WIDTH,
  input wire logic [4:0] SYNTH_INPUT_DIVIDER,
  input wire logic [4:0] SYNTH_OUTPUT_DIVIDER,
  input wire logic [4:0] SYNTH_FEEDBACK_MULT,
  input wire logic [2:0] VCO_MULT,
  input wire logic PANEL_ENABLE,
  input wire logic PANEL_GRAY,
  input wire logic SHIFT_FALLING_EDGE,
  input wire logic FRAME_SYNC_ACTIVE_HIGH,
  // sequencer
  input wire logic [7:0] ACTIVE_CMD,
  input wire logic [3:0] PARAM_INDEX,
  input wire logic PARAM_OVERRUN
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  // decoded fields follow raw registers one edge later
  property p_sys_flags;
    1 |-> {CHAR_ROM_INTERNAL, CHAR_EIGHT_LINES, TOP_LINE_COMP_EN} ==
      ~{$past(SYSTEM_SETUP_FLAGS[0]), $past(SYSTEM_SETUP_FLAGS[2]), $past(SYSTEM_SETUP_FLAGS[5])};
  endproperty
  a_sys_flags: assert property (p_sys_flags) else $error("flag decode wrong");
  property p_drive;
    1 |-> DRIVE_MODE == ($past(CHAR_WIDTH_CFG[7]) && !$past(PANEL_IF_CONTROL[0]));
  endproperty
  a_drive: assert property (p_drive) else $error("drive mode not gated");
  property p_char_size;
    1 |-> {CHAR_WIDTH, CHAR_HEIGHT} ==
      {{1'b0, $past(CHAR_WIDTH_CFG[3:0])} + 5'h01, {1'b0, $past(CHAR_HEIGHT_CFG[3:0])} + 5'h01};
  endproperty
  a_char_size: assert property (p_char_size) else $error("char size wrong");
  property p_line_count;
    1 |-> LINE_DISPLAY_COUNT == {1'b0, $past(LINE_DISPLAY_ADDRESSES)} + 9'h001;
  endproperty
  a_line_count: assert property (p_line_count) else $error("line count wrong");
  property p_vwidth;
    1 |-> VIRTUAL_WIDTH == {$past(VIRTUAL_WIDTH_HIGH[6:0]), $past(VIRTUAL_WIDTH_LOW)};
  endproperty
  a_vwidth: assert property (p_vwidth) else $error("virtual width wrong");
  property p_synth;
    1 |-> {SYNTH_INPUT_DIVIDER, SYNTH_OUTPUT_DIVIDER, SYNTH_FEEDBACK_MULT} ==
      {{1'b0, $past(PLL_DIVIDERS[3:0])} + 5'h01, {1'b0, $past(PLL_DIVIDERS[7:4])} + 5'h01,
      {1'b0, $past(PLL_MULTIPLIER[3:0])} + 5'h01};
  endproperty
  a_synth: assert property (p_synth) else $error("synth divider wrong");
  property p_vco;
    1 |-> VCO_MULT == {1'b0, $past(PLL_VCO_CFG[6:5])} + 3'h1;
  endproperty
  a_vco: assert property (p_vco) else $error("vco multiplier wrong");
  property p_panel;
    1 |-> {PANEL_ENABLE, PANEL_GRAY, SHIFT_FALLING_EDGE, FRAME_SYNC_ACTIVE_HIGH} ==
      {$past(PANEL_IF_CONTROL[0]), ~$past(PANEL_IF_CONTROL[1]), ~$past(PANEL_IF_CONTROL[4]),
      $past(PANEL_IF_CONTROL[7])};
  endproperty
  a_panel: assert property (p_panel) else $error("panel decode wrong");
  // flag and panel control writes only land through the owning command, status trails by one edge
  property p_sys_seq;
    $changed(SYSTEM_SETUP_FLAGS) |=> ACTIVE_CMD == 8'h40 && PARAM_INDEX == 4'h1;
  endproperty
  a_sys_seq: assert property (p_sys_seq) else $error("flags written out of order");
  property p_panel_seq;
    $changed(PANEL_IF_CONTROL) |=> ACTIVE_CMD == 8'h63 && PARAM_INDEX == 4'h1;
  endproperty
  a_panel_seq: assert property (p_panel_seq) else $error("panel written out of order");
  property p_quiet;
    HOST_WR_N [*8] |-> $stable({ACTIVE_CMD, PARAM_INDEX, PARAM_OVERRUN});
  endproperty
  a_quiet: assert property (p_quiet) else $error("sequencer moved without strobe");
  property p_overrun;
    $rose(PARAM_OVERRUN) |-> $stable(PARAM_INDEX);
  endproperty
  a_overrun: assert property (p_overrun) else $error("dropped byte counted");
  // main scenarios reached
  c_overrun: cover property ($rose(PARAM_OVERRUN));
  c_panel_on: cover property ($rose(PANEL_ENABLE));
  c_vwidth: cover property ($changed(VIRTUAL_WIDTH));
endmodule // pcc_cfg_monitor

bind pcc_panel_command_config pcc_cfg_monitor pcc_cfg_monitor_inst (.*);

// File: testbench/tb_panel_command_config.sv
// self-checking bench of the command configuration block
`timescale 1ns/100ps
module tb_panel_command_config;
  logic SYS_CLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] HOST_DATA, ACTIVE_CMD, SYSTEM_SETUP_FLAGS, CHAR_WIDTH_CFG, CHAR_HEIGHT_CFG, LINE_DISPLAY_ADDRESSES;
  logic [7:0] LINE_TOTAL_ADDRESSES, FRAME_DISPLAY_LINES, VIRTUAL_WIDTH_LOW, VIRTUAL_WIDTH_HIGH, PLL_DIVIDERS;
  logic [7:0] PLL_MULTIPLIER, PLL_VCO_CFG, PANEL_IF_CONTROL;
  logic HOST_CMD, HOST_WR_N, byte_done, CHAR_ROM_INTERNAL, CHAR_EIGHT_LINES, SCREEN_MODE, SCREEN_MODE_CONFLICT;
  logic TOP_LINE_COMP_EN, DRIVE_MODE, PANEL_ENABLE, PANEL_GRAY, PANEL_SCALE_NEAREST, SHIFT_FALLING_EDGE;
  logic DATA_READY_ACTIVE_HIGH, LINE_SYNC_ACTIVE_HIGH, FRAME_SYNC_ACTIVE_HIGH, PARAM_OVERRUN, eo;
  logic [4:0] CHAR_WIDTH, CHAR_HEIGHT, SYNTH_INPUT_DIVIDER, SYNTH_OUTPUT_DIVIDER, SYNTH_FEEDBACK_MULT;
  logic [4:0] LOOP_CAPACITOR_SELECT;
  logic [8:0] LINE_DISPLAY_COUNT, LINE_TOTAL_COUNT, FRAME_LINE_COUNT;
  logic [14:0] VIRTUAL_WIDTH;
  logic [3:0] LOOP_RESISTOR_SELECT, PARAM_INDEX, ei;
  logic [2:0] VCO_MULT;
  logic [7:0] er [12];
  logic [7:0] ec;
  logic [108:0] notes [$];
  logic [8:0] doc [15] = '{9'h140, 9'h030, 9'h007, 9'h007, 9'h027, 9'h036, 9'h0EF, 9'h050, 9'h000,
    9'h162, 9'h021, 9'h099, 9'h024, 9'h163, 9'h025};
  int n_fail = 0, cmp_count = 0, cyc = 0, seed = 32'hA382, r, m;

  pcc_panel_command_config pcc_panel_command_config_inst (.*);
  pcc_host_model pcc_host_model_inst (.*);

  // 10 MHz system clock
  initial forever #50 SYS_CLK = ~SYS_CLK;

  // state and field comparisons
  task automatic cmp_state(input string nm, input logic [108:0] e, input logic [108:0] g);
    cmp_count++;
    if (e !== g) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_field(input string nm, input logic [127:0] e, input logic [127:0] g);
    cmp_count++;
    if (e !== g) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // expected decode of a raw register bank
  function automatic logic [91:0] dec(input logic [108:0] s);
    logic [7:0] q [12];
    for (int i = 0; i < 12; i++) q[i] = s[108 - 8 * i -: 8];
    return {~q[0][0], ~q[0][2], q[0][3] & ~q[11][0], q[0][3] & q[11][0], ~q[0][5], q[1][7] & ~q[11][0],
      {1'b0, q[1][3:0]} + 5'h01, {1'b0, q[2][3:0]} + 5'h01, {1'b0, q[3]} + 9'h001, {1'b0, q[4]} + 9'h001,
      {1'b0, q[5]} + 9'h001, {q[7][6:0], q[6]}, {1'b0, q[8][3:0]} + 5'h01, {1'b0, q[8][7:4]} + 5'h01,
      {1'b0, q[9][3:0]} + 5'h01, q[9][7:4], q[10][4:0], {1'b0, q[10][6:5]} + 3'h1,
      q[11][0], ~q[11][1], q[11][2], ~q[11][4], q[11][5], q[11][6], q[11][7]};
  endfunction

  // compare all outputs against one expected bank
  task automatic check_now(input logic [108:0] s);
    logic [91:0] d;
    d = dec(s);
    cmp_state("registers", s,
      {SYSTEM_SETUP_FLAGS, CHAR_WIDTH_CFG, CHAR_HEIGHT_CFG, LINE_DISPLAY_ADDRESSES,
      LINE_TOTAL_ADDRESSES, FRAME_DISPLAY_LINES, VIRTUAL_WIDTH_LOW, VIRTUAL_WIDTH_HIGH, PLL_DIVIDERS,
      PLL_MULTIPLIER, PLL_VCO_CFG, PANEL_IF_CONTROL, ACTIVE_CMD, PARAM_INDEX, PARAM_OVERRUN});
    cmp_field("system fields", d[91:34],
      {CHAR_ROM_INTERNAL, CHAR_EIGHT_LINES, SCREEN_MODE, SCREEN_MODE_CONFLICT,
      TOP_LINE_COMP_EN, DRIVE_MODE, CHAR_WIDTH, CHAR_HEIGHT, LINE_DISPLAY_COUNT, LINE_TOTAL_COUNT,
      FRAME_LINE_COUNT, VIRTUAL_WIDTH});
    cmp_field("synth fields", d[33:7],
      {SYNTH_INPUT_DIVIDER, SYNTH_OUTPUT_DIVIDER, SYNTH_FEEDBACK_MULT,
      LOOP_RESISTOR_SELECT, LOOP_CAPACITOR_SELECT, VCO_MULT});
    cmp_field("panel fields", d[6:0],
      {PANEL_ENABLE, PANEL_GRAY, PANEL_SCALE_NEAREST, SHIFT_FALLING_EDGE,
      DATA_READY_ACTIVE_HIGH, LINE_SYNC_ACTIVE_HIGH, FRAME_SYNC_ACTIVE_HIGH});
  endtask

  function automatic logic [108:0] model_state();
    return {er[0], er[1], er[2], er[3], er[4], er[5], er[6], er[7], er[8], er[9], er[10], er[11], ec, ei, eo};
  endfunction

  // update the model, note the result, drive the byte
  task automatic send(input logic c, input logic [7:0] d);
    int n, b;
    n = (ec == 8'h40) ? 8 : (ec == 8'h62) ? 3 : (ec == 8'h63) ? 1 : 0;
    b = (ec == 8'h62) ? 8 : (ec == 8'h63) ? 11 : 0;
    if (c) begin
      ec = d;
      ei = 4'h0;
      eo = 1'b0;
    end else if (ei < n) begin
      er[b + ei] = d;
      ei++;
    end else eo = 1'b1;
    notes.push_back(model_state());
    pcc_host_model_inst.put(c, d, {$random(seed)} % 3);
  endtask

  // reset for 12 cycles, then expect cleared state
  task automatic do_reset();
    @(negedge SYS_CLK);
    SRST = 1'b1;
    repeat (12) @(negedge SYS_CLK);
    SRST = 1'b0;
    foreach (er[i]) er[i] = 8'h00;
    ec = 8'h00;
    ei = 4'h0;
    eo = 1'b0;
    repeat (2) @(negedge SYS_CLK);
    check_now(model_state());
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // scoreboard: oldest note against outputs after each byte
  initial forever begin
    @(posedge byte_done);
    check_now(notes.pop_front());
  end

  // hang guard
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      summarize();
    end
  end

  // main sequence
  initial begin
    do_reset();
    foreach (doc[i]) send(doc[i][8], doc[i][7:0]);
    repeat (10) @(negedge SYS_CLK);
    cmp_field("example counts",
      {5'h08, 5'h08, 9'h028, 9'h037, 9'h0F0, 15'h0050, 5'h02, 5'h03, 5'h0A, 3'h2},
      {CHAR_WIDTH, CHAR_HEIGHT, LINE_DISPLAY_COUNT, LINE_TOTAL_COUNT, FRAME_LINE_COUNT, VIRTUAL_WIDTH,
      SYNTH_INPUT_DIVIDER, SYNTH_OUTPUT_DIVIDER, SYNTH_FEEDBACK_MULT, VCO_MULT});
    cmp_field("example flags", 11'h3E6,
      {TOP_LINE_COMP_EN, PANEL_ENABLE, PANEL_GRAY, PANEL_SCALE_NEAREST,
      SHIFT_FALLING_EDGE, DATA_READY_ACTIVE_HIGH, LINE_SYNC_ACTIVE_HIGH, FRAME_SYNC_ACTIVE_HIGH,
      CHAR_ROM_INTERNAL, CHAR_EIGHT_LINES, SCREEN_MODE_CONFLICT});
    send(1'b0, 8'hA5); // surplus panel byte dropped
    send(1'b1, 8'h62);
    repeat (4) send(1'b0, 8'($random(seed)));
    send(1'b1, 8'h42); // unknown code, the two bytes after it are dropped as orphans
    send(1'b0, 8'h20);
    send(1'b0, 8'h00);
    for (int k = 0; k < 12; k++) begin
      r = {$random(seed)} % 4;
      send(1'b1, r == 0 ? 8'h40 : r == 1 ? 8'h62 : r == 2 ? 8'h63 : 8'($random(seed)));
      m = {$random(seed)} % 10;
      repeat (m) send(1'b0, 8'($random(seed)));
    end
    do_reset();
    send(1'b1, 8'h63);
    send(1'b0, 8'h81);
    summarize();
  end
endmodule // tb_panel_command_config
